// *** hw/gfs_pkg.sv ***
package gfs_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS      = 10;
	localparam int TICK_NS     = 1_000_000;                // 1 ms time base
	localparam int TICK_CYC    = TICK_NS / CLK_NS;
	localparam int PROMPT_MS   = 1000;                     // Hold until prompt shows
	localparam int ENTER_MS    = PROMPT_MS + 3000;         // Prompt plus further 3 s
	localparam int SAVE_MS     = 3000;
	localparam int VIEW_MS     = 1000;
	localparam int STEP_MS     = 2000;
	localparam int SWIPE_MS    = 1000;
	localparam int MENU_TO_MS  = 15000;
	localparam int SCROLLS     = 4;
	localparam int MSG_MS      = 60000;
	localparam int FLASH_MS    = 500;
	localparam int DAY_MS      = 86_400_000;
	localparam int SPAN_DAYS   = 180;
	// ****************************************
	// Limits (mA, mV, degC, %LEL, %)
	// ****************************************
	localparam int CUR_NOM     = 200;
	localparam int CUR_TOL     = 50;
	localparam int VBR_LO      = 1800;
	localparam int VBR_HI      = 3500;
	localparam int VIN_LO      = 11500;
	localparam int VIN_HI      = 28000;
	localparam int TMP_LO      = -40;
	localparam int TMP_HI      = 75;
	localparam int ZERO_LIM    = -10;
	localparam int FULL_SCALE  = 100;
	localparam int LIFE_MAX    = 100;
	localparam int LIFE_REPL   = 25;
	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam logic [4:0] OFF_CTRL   = 5'h00;
	localparam logic [4:0] OFF_FAULT  = 5'h04;
	localparam logic [4:0] OFF_STATUS = 5'h08;
	localparam logic [4:0] OFF_DAYS   = 5'h0C;
	localparam logic [4:0] OFF_LIFE   = 5'h10;
	localparam int CTRL_LATCH  = 0;
	localparam int CTRL_CAL    = 1;
	localparam int CTRL_MENU   = 2;
	localparam int NFAULT      = 12;

	typedef enum logic [1:0] {LOOP_NORMAL, LOOP_OVER, LOOP_CAL, LOOP_FAULT} gfs_loop_e;
	typedef enum logic [1:0] {ST_NORMAL, ST_VIEW, ST_MENU, ST_SHOW} gfs_state_e;

	typedef struct packed {
		logic spanDue;
		logic temp;
		logic supply;
		logic loop;
		logic memory;
		logic processor;
		logic voltage;
		logic current;
		logic clearing;
		logic stability;
		logic range;
		logic zero;
	} gfs_fault_s;

	typedef struct packed {
		logic signed [15:0] conc;     // %LEL
		logic        [15:0] bridgeMa;
		logic        [15:0] bridgeMv;
		logic        [15:0] supplyMv;
		logic signed [15:0] tempC;
	} gfs_meas_s;

	typedef struct packed {
		logic       zeroOk;
		logic       spanOk;
		logic       spanFailRange;
		logic       spanFailStab;
		logic       spanFailClear;
		logic [7:0] lifeIn;
	} gfs_cal_s;
endpackage : gfs_pkg

// *** hw/gfs_pad.sv ***
`timescale 1ns/1ps
module gfs_pad
	import gfs_pkg::*;
(
	input  wire logic        clk,     // System clock
	input  wire logic        rst,     // Sync reset
	input  wire logic        ce,      // Clock enable
	input  wire logic        tick,    // 1 ms strobe
	input  wire logic        padIn,   // Raw magnet pad
	output logic             padOn,   // Filtered level
	output logic             swipe,   // Short touch released
	output logic      [15:0] heldMs   // Hold time so far
);
	logic [2:0] syncReg;

	always_ff @(posedge clk) begin
		if (rst)
			syncReg <= 3'h0;
		else if (ce)
			syncReg <= {syncReg[1:0], padIn};
	end

	// Level changes only once stages two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			padOn <= 1'b0;
			swipe <= 1'b0;
		end else if (ce) begin
			swipe <= 1'b0;
			if (syncReg[1] == syncReg[2]) begin
				padOn <= syncReg[2];
				if (padOn && !syncReg[2] && heldMs < 16'(SWIPE_MS))
					swipe <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			heldMs <= 16'h0000;
		else if (ce) begin
			if (!padOn)
				heldMs <= 16'h0000;
			else if (tick && heldMs != 16'hFFFF)
				heldMs <= heldMs + 16'h0001;
		end
	end
endmodule : gfs_pad

// *** hw/gfs_range.sv ***
`timescale 1ns/1ps
module gfs_range #(
	parameter int LO = 0,
	parameter int HI = 0
) (
	input  wire logic signed [15:0] value,   // Measured value
	output logic                    outside  // Below LO or above HI
);
	assign outside = (32'(value) < LO) || (32'(value) > HI);
endmodule : gfs_range

// *** hw/gfs_fault_supervisor.sv ***
`timescale 1ns/1ps
module gfs_fault_supervisor
	import gfs_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC   // Shorten for simulation
) (
	input  wire logic        clk,                // 100 MHz clock
	input  wire logic        rst,                // Sync reset, high
	input  wire logic        ce,                 // Clock enable
	input  wire logic [4:0]  avs_address,        // Byte address
	input  wire logic        avs_read,           // Read request
	input  wire logic        avs_write,          // Write request
	input  wire logic [31:0] avs_writedata,      // Write data
	input  wire logic [3:0]  avs_byteenable,     // Byte lanes
	output logic      [31:0] avs_readdata,       // Read data
	output logic             avs_waitrequest,    // Stall
	input  wire logic        magnet_pad_up,      // Pad pin
	input  wire logic        magnet_pad_down,    // Pad pin
	input  gfs_meas_s        meas,               // Digitised measurements
	input  gfs_cal_s         cal,                // Calibration results
	input  wire logic        procErr,            // Controller run-time error
	input  wire logic        memWriteFail,       // NV store failed
	input  wire logic        loopBad,            // Output loop not working
	output logic             faultLed,           // Fault indicator
	output logic             faultMsg,           // Start fault message scroll
	output logic             overFlash,          // Flash full-scale reading
	output gfs_loop_e        loopLevel,          // Loop output level
	output gfs_state_e       dispState,          // Display mode
	output logic      [3:0]  dispFault,          // Fault index shown
	output logic             dispChoice,         // Shown yes/no
	output logic      [7:0]  sensorLife,         // Remaining life %
	output logic             replaceCell         // Life below threshold
);
	// ****************************************
	// Time base and pads
	// ****************************************
	logic [31:0] tickCnt;
	logic        tick;
	logic        upOn, dnOn, upSwipe, dnSwipe;
	logic [15:0] upHeld, dnHeld, held;
	logic        padOn, swipeAny;

	always_ff @(posedge clk) begin
		if (rst) begin
			tickCnt <= 32'h0000_0000;
			tick    <= 1'b0;
		end else if (ce) begin
			tick    <= (tickCnt == 32'(TICK_CYCLES - 1));
			tickCnt <= (tickCnt == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tickCnt + 32'h0000_0001;
		end
	end

	gfs_pad padUp (
		.clk    (clk),
		.rst    (rst),
		.ce     (ce),
		.tick   (tick),
		.padIn  (magnet_pad_up),
		.padOn  (upOn),
		.swipe  (upSwipe),
		.heldMs (upHeld)
	);
	gfs_pad padDn (
		.clk    (clk),
		.rst    (rst),
		.ce     (ce),
		.tick   (tick),
		.padIn  (magnet_pad_down),
		.padOn  (dnOn),
		.swipe  (dnSwipe),
		.heldMs (dnHeld)
	);
	assign padOn    = upOn | dnOn;
	assign swipeAny = upSwipe | dnSwipe;
	assign held     = (upHeld > dnHeld) ? upHeld : dnHeld;

	// ****************************************
	// Fault detection
	// ****************************************
	gfs_fault_s fault, faultReg;
	logic       curOut, vbrOut, vinOut, tmpOut;
	logic       anyFault, hardFault;
	logic [31:0] dayMs;
	logic [7:0]  days;

	gfs_range #(.LO(CUR_NOM - CUR_TOL), .HI(CUR_NOM + CUR_TOL)) chkCur (.value(meas.bridgeMa), .outside(curOut));
	gfs_range #(.LO(VBR_LO), .HI(VBR_HI)) chkVbr (.value(meas.bridgeMv), .outside(vbrOut));
	gfs_range #(.LO(VIN_LO), .HI(VIN_HI)) chkVin (.value(meas.supplyMv), .outside(vinOut));
	gfs_range #(.LO(TMP_LO), .HI(TMP_HI)) chkTmp (.value(meas.tempC), .outside(tmpOut));

	// Calibration faults are sticky; a new failure wins over a clear
	always_ff @(posedge clk) begin
		if (rst) begin
			faultReg           <= '0;
			faultReg.range     <= 1'b0;
			faultReg.stability <= 1'b0;
			faultReg.clearing  <= 1'b0;
		end else if (ce) begin
			if (32'(meas.conc) < ZERO_LIM)
				faultReg.zero <= 1'b1;
			else if (cal.zeroOk)
				faultReg.zero <= 1'b0;
			faultReg.range     <= cal.spanFailRange | (faultReg.range & ~cal.spanOk);
			faultReg.stability <= cal.spanFailStab | (faultReg.stability & ~cal.spanOk);
			faultReg.clearing  <= cal.spanFailClear | (faultReg.clearing & ~cal.spanOk);
		end
	end

	// Day count since last good span
	always_ff @(posedge clk) begin
		if (rst) begin
			dayMs <= 32'h0000_0000;
			days  <= 8'h00;
		end else if (ce) begin
			if (cal.spanOk) begin
				dayMs <= 32'h0000_0000;
				days  <= 8'h00;
			end else if (tick) begin
				dayMs <= (dayMs == 32'(DAY_MS - 1)) ? 32'h0000_0000 : dayMs + 32'h0000_0001;
				if (dayMs == 32'(DAY_MS - 1) && days != 8'hFF)
					days <= days + 8'h01;
			end
		end
	end

	always_comb begin
		fault           = faultReg;
		fault.current   = curOut;
		fault.voltage   = vbrOut;
		fault.processor = procErr;
		fault.memory    = memWriteFail;
		fault.loop      = loopBad;
		fault.supply    = vinOut;
		fault.temp      = tmpOut;
		fault.spanDue   = (days >= 8'(SPAN_DAYS));
	end
	assign anyFault  = |fault;
	assign hardFault = |(fault & ~gfs_fault_s'({1'b1, 1'b1, 10'h000}));

	// ****************************************
	// Control register and bus slave
	// ****************************************
	logic latchCfg, calActive, menuReq, menuSave, shown;

	// Menu save takes priority over a bus write in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			latchCfg  <= 1'b0;
			calActive <= 1'b0;
			menuReq   <= 1'b0;
		end else if (ce) begin
			menuReq <= 1'b0;
			if (avs_write && !avs_waitrequest && avs_address == OFF_CTRL && avs_byteenable[0]) begin
				latchCfg  <= avs_writedata[CTRL_LATCH];
				calActive <= avs_writedata[CTRL_CAL];
				menuReq   <= avs_writedata[CTRL_MENU];
			end
			if (menuSave)
				latchCfg <= shown;
		end
	end

	// One wait cycle, then the access completes
	always_ff @(posedge clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if (ce) begin
			if ((avs_read || avs_write) && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				unique case (avs_address)
					OFF_CTRL:   avs_readdata <= {29'h0, 1'b0, calActive, latchCfg};
					OFF_FAULT:  avs_readdata <= {20'h0_0000, fault};
					OFF_STATUS: avs_readdata <= {26'h000_0000, replaceCell, faultLed, dispState, loopLevel};
					OFF_DAYS:   avs_readdata <= {24'h00_0000, days};
					OFF_LIFE:   avs_readdata <= {24'h00_0000, sensorLife};
					default:    avs_readdata <= 32'h0000_0000;
				endcase
			end else
				avs_waitrequest <= 1'b1;
		end
	end

	// ****************************************
	// Indicator, loop and life
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst)
			faultLed <= 1'b0;
		else if (ce) begin
			if (!latchCfg)
				faultLed <= anyFault;
			else if (anyFault)
				faultLed <= 1'b1;
			else if (swipeAny)
				faultLed <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			loopLevel <= LOOP_NORMAL;
		else if (ce) begin
			if (calActive)
				loopLevel <= LOOP_CAL;
			else if (hardFault)
				loopLevel <= LOOP_FAULT;
			else if (32'(meas.conc) > FULL_SCALE)
				loopLevel <= LOOP_OVER;
			else
				loopLevel <= LOOP_NORMAL;
		end
	end

	logic [15:0] flashMs;

	always_ff @(posedge clk) begin
		if (rst) begin
			overFlash <= 1'b0;
			flashMs   <= 16'h0000;
		end else if (ce) begin
			if (32'(meas.conc) <= FULL_SCALE) begin
				overFlash <= 1'b0;
				flashMs   <= 16'h0000;
			end else if (tick) begin
				flashMs <= (flashMs == 16'(FLASH_MS - 1)) ? 16'h0000 : flashMs + 16'h0001;
				if (flashMs == 16'(FLASH_MS - 1))
					overFlash <= ~overFlash;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sensorLife  <= 8'(LIFE_MAX);
			replaceCell <= 1'b0;
		end else if (ce && cal.spanOk) begin
			sensorLife  <= (cal.lifeIn > 8'(LIFE_MAX)) ? 8'(LIFE_MAX) : cal.lifeIn;
			replaceCell <= (cal.lifeIn < 8'(LIFE_REPL));
		end
	end

	// ****************************************
	// Periodic fault message
	// ****************************************
	logic [15:0] msgMs;

	always_ff @(posedge clk) begin
		if (rst) begin
			msgMs    <= 16'h0000;
			faultMsg <= 1'b0;
		end else if (ce) begin
			faultMsg <= 1'b0;
			if (!anyFault || dispState != ST_NORMAL)
				msgMs <= 16'h0000;
			else if (tick) begin
				msgMs <= (msgMs == 16'(MSG_MS - 1)) ? 16'h0000 : msgMs + 16'h0001;
				faultMsg <= (msgMs == 16'(MSG_MS - 1));
			end
		end
	end

	// ****************************************
	// Display and menu state machine
	// ****************************************
	gfs_state_e state;
	logic [15:0] tmrMs;
	logic        armed;

	assign menuSave = (state == ST_SHOW) && armed && held >= 16'(SAVE_MS);

	always_ff @(posedge clk) begin
		if (rst) begin
			state     <= ST_NORMAL;
			tmrMs     <= 16'h0000;
			armed     <= 1'b0;
			shown     <= 1'b0;
			dispFault <= 4'h0;
		end else if (ce) begin
			if (tick)
				tmrMs <= tmrMs + 16'h0001;
			unique case (state)
				ST_NORMAL: begin
					if (menuReq) begin
						state <= ST_MENU;
						tmrMs <= 16'h0000;
					end else if (anyFault && held >= 16'(VIEW_MS)) begin
						state     <= ST_VIEW;
						dispFault <= 4'h0;
						tmrMs     <= 16'h0000;
					end
				end
				ST_VIEW: begin
					if (!fault[dispFault] || tmrMs >= 16'(STEP_MS)) begin
						tmrMs <= 16'h0000;
						if (dispFault == 4'(NFAULT - 1))
							state <= ST_NORMAL;
						else
							dispFault <= dispFault + 4'h1;
					end
				end
				ST_MENU: begin
					if (padOn)
						tmrMs <= 16'h0000;
					if (held >= 16'(ENTER_MS)) begin
						state <= ST_SHOW;
						shown <= latchCfg;
						armed <= 1'b0;
						tmrMs <= 16'h0000;
					end else if (!padOn && tmrMs >= 16'(MENU_TO_MS))
						state <= ST_NORMAL;
				end
				ST_SHOW: begin
					if (!padOn)
						armed <= 1'b1;
					if (padOn)
						tmrMs <= 16'h0000;
					if (swipeAny && armed)
						shown <= ~shown;
					if (menuSave) begin
						state <= ST_MENU;
						tmrMs <= 16'h0000;
					end else if (!padOn && tmrMs >= 16'(MENU_TO_MS))
						state <= ST_NORMAL;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dispState  <= ST_NORMAL;
			dispChoice <= 1'b0;
		end else if (ce) begin
			dispState  <= state;
			dispChoice <= shown;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_led_nonlatch: assert property (@(posedge clk) disable iff (rst)
		ce && !latchCfg && !anyFault |=> !faultLed)
		else $error("Indicator stays on without fault");
	a_led_latch_hold: assert property (@(posedge clk) disable iff (rst)
		ce && latchCfg && faultLed && !swipeAny && $stable(latchCfg) |=> faultLed)
		else $error("Latched indicator dropped without swipe");
	a_save_value: assert property (@(posedge clk) disable iff (rst)
		ce && menuSave |=> latchCfg == $past(shown) && state == ST_MENU)
		else $error("Shown value not saved");
	a_menu_timeout: assert property (@(posedge clk) disable iff (rst)
		ce && state == ST_MENU && !padOn && held < 16'(ENTER_MS) && tmrMs >= 16'(MENU_TO_MS) |=> state == ST_NORMAL)
		else $error("Menu did not time out");
	a_cal_level: assert property (@(posedge clk) disable iff (rst)
		ce && calActive |=> loopLevel == LOOP_CAL)
		else $error("Loop not at calibration level");
	a_hard_zero: assert property (@(posedge clk) disable iff (rst)
		ce && !calActive && hardFault |=> loopLevel == LOOP_FAULT)
		else $error("Hard fault not at 0mA");
	a_soft_normal: assert property (@(posedge clk) disable iff (rst)
		ce && !calActive && !hardFault && fault.temp && 32'(meas.conc) <= FULL_SCALE |=> loopLevel == LOOP_NORMAL)
		else $error("Temperature fault changed loop");
	a_zero_sticky: assert property (@(posedge clk) disable iff (rst)
		ce && faultReg.zero && !cal.zeroOk |=> faultReg.zero)
		else $error("Zero fault lost without zero cal");
	a_span_clear: assert property (@(posedge clk) disable iff (rst)
		ce && cal.spanOk && !cal.spanFailRange |=> !faultReg.range)
		else $error("Range fault not cleared by span");
	a_msg_quiet: assert property (@(posedge clk) disable iff (rst)
		faultMsg |-> $past(anyFault) && $past(dispState) == ST_NORMAL)
		else $error("Fault message without fault");
endmodule : gfs_fault_supervisor

// *** verif/gfs_operator.sv ***
`timescale 1ns/1ps
// ****************************************
// Magnet operator and loop receiver
// ****************************************
module gfs_operator
	import gfs_pkg::*;
(
	input  wire logic        clk,       // System clock
	input  wire logic        rst,       // Sync reset
	input  wire logic        go,        // Start a touch
	input  wire logic        sel,       // 0 up pad, 1 down pad
	input  wire logic [31:0] holdCyc,   // Touch length in cycles
	input  gfs_loop_e        loopLevel, // Loop level seen
	output logic             padUp,     // Pad pin
	output logic             padDown,   // Pad pin
	output logic      [15:0] loopMa10   // Loop current, 0.1 mA
);
	logic [31:0] cntReg;
	logic        selReg;
	// Short count is a swipe, long count a hold; magnet absent reads low
	always_ff @(posedge clk) begin
		if (rst) begin
			cntReg <= '0;
			selReg <= 1'b0;
		end else if (go) begin
			cntReg <= holdCyc;
			selReg <= sel;
		end else if (cntReg != 0) begin
			cntReg <= cntReg - 1;
		end
	end
	assign padUp   = (cntReg != 0) && !selReg;
	assign padDown = (cntReg != 0) && selReg;
	// Normal level is a plain live-zero figure; the receiver only tells the bands apart
	always_comb begin
		case (loopLevel)
			LOOP_OVER:  loopMa10 = 16'd220;
			LOOP_CAL:   loopMa10 = 16'd20;
			LOOP_FAULT: loopMa10 = 16'd0;
			default:    loopMa10 = 16'd40;
		endcase
	end
endmodule : gfs_operator

// *** verif/gfs_fault_supervisor_test.sv ***
`timescale 1ns/1ps
module gfs_fault_supervisor_test;
	import gfs_pkg::*;
	logic clk = 0, rst = 1, rd = 0, wr = 0, go = 0, sel = 0, procErr = 0, memFail = 0, loopBad = 0;
	logic [4:0] addr = '0;
	logic [31:0] wdata = '0, rdata, hold = '0, d;
	logic waitReq, padUp, padDown, faultLed, faultMsg, overFlash, dispChoice, replaceCell;
	logic [15:0] loopMa10;
	logic [7:0] sensorLife;
	logic [3:0] dispFault;
	gfs_meas_s meas = '{conc: 0, bridgeMa: 200, bridgeMv: 2700, supplyMv: 24000, tempC: 25};
	gfs_cal_s cal = '0;
	gfs_loop_e loopLevel;
	gfs_state_e dispState;
	int n_mismatch = 0, n_tests = 0;
	gfs_fault_supervisor #(.TICK_CYCLES(1)) uut (.clk(clk), .rst(rst), .ce(1'b1), .avs_address(addr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
		.avs_waitrequest(waitReq), .magnet_pad_up(padUp), .magnet_pad_down(padDown), .meas(meas), .cal(cal),
		.procErr(procErr), .memWriteFail(memFail), .loopBad(loopBad), .faultLed(faultLed), .faultMsg(faultMsg),
		.overFlash(overFlash), .loopLevel(loopLevel), .dispState(dispState), .dispFault(dispFault),
		.dispChoice(dispChoice), .sensorLife(sensorLife), .replaceCell(replaceCell));
	gfs_operator op (.clk(clk), .rst(rst), .go(go), .sel(sel), .holdCyc(hold), .loopLevel(loopLevel),
		.padUp(padUp), .padDown(padDown), .loopMa10(loopMa10));
	initial forever #5 clk = ~clk;
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
		int k;
		@(posedge clk);
		addr <= a; wdata <= v; wr <= w; rd <= !w;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (waitReq === 1'b0) break;
		end
		if (k == 50) begin n_mismatch++; final_report(); end
		d = rdata;
		wr <= 1'b0; rd <= 1'b0;
	endtask : bus
	// Starts a touch; the operator model times its length
	task automatic press(input logic s, input int n);
		@(posedge clk);
		go <= 1;
		sel <= s;
		hold <= n;
		@(posedge clk);
		go <= 0;
	endtask : press
	task automatic calPulse(input gfs_cal_s v);
		@(posedge clk); cal <= v;
		@(posedge clk); cal <= {5'b0, v.lifeIn};
		repeat (2) @(posedge clk);
	endtask : calPulse
	// Bounded wait for a design flag to reach a level
	task automatic waitFor(ref logic s, input logic lvl, input int lim);
		int k;
		for (k = 0; k < lim && s !== lvl; k++) @(posedge clk);
		if (k == lim) begin n_mismatch++; final_report(); end
	endtask : waitFor
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic tResetRegs();
		bus(0, OFF_STATUS, 0); check(d, 32'h0000_0000);
		bus(0, OFF_LIFE, 0);   check(d, 32'h0000_0064);
		bus(0, OFF_FAULT, 0);  check(d, 32'h0000_0000);
		bus(0, 5'h14, 0);      check(d, 32'h0000_0000);
		bus(1, OFF_FAULT, 32'h0000_0FFF); bus(0, OFF_FAULT, 0); check(d, 32'h0000_0000);
	endtask : tResetRegs
	task automatic tLimits();
		int i;
		for (i = 0; i < 12; i++) begin
			@(posedge clk);
			case (i)
				0: meas.bridgeMa <= 149;  1: meas.bridgeMa <= 251;   2: meas.bridgeMv <= 3501;
				3: meas.bridgeMv <= 1799; 4: procErr <= 1;           5: memFail <= 1;
				6: loopBad <= 1;          7: meas.supplyMv <= 11499; 8: meas.supplyMv <= 28001;
				9: meas.tempC <= -41;     10: meas.tempC <= 76;
				default: meas <= '{conc: 0, bridgeMa: 150, bridgeMv: 3500, supplyMv: 28000, tempC: 75};
			endcase
			repeat (2) @(posedge clk);
			bus(0, OFF_FAULT, 0);
			check(d, (i == 11) ? 0 : 32'(1) << (i < 2 ? 4 : i < 4 ? 5 : i < 7 ? i + 2 : i < 9 ? 9 : 10));
			check(loopMa10, (i < 9) ? 0 : 40);
			check(faultLed, i < 11);
			@(posedge clk);
			meas <= '{conc: 0, bridgeMa: 200, bridgeMv: 2700, supplyMv: 24000, tempC: 25};
			procErr <= 0; memFail <= 0; loopBad <= 0;
			repeat (3) @(posedge clk);
			check(faultLed, 0);
		end
	endtask : tLimits
	task automatic tOverAndCal();
		@(posedge clk); meas.conc <= 101;
		repeat (2) @(posedge clk);
		check(loopMa10, 220);
		waitFor(overFlash, 1, 6000);
		@(posedge clk); meas.conc <= 0; procErr <= 1;
		bus(1, OFF_CTRL, 32'h0000_0002);
		repeat (2) @(posedge clk);
		check(loopMa10, 20);
		bus(1, OFF_CTRL, 32'h0000_0000);
		repeat (2) @(posedge clk);
		check(loopMa10, 0);
		@(posedge clk); procErr <= 0;
	endtask : tOverAndCal
	task automatic tCalFaults();
		@(posedge clk); meas.conc <= -11;
		repeat (2) @(posedge clk);
		@(posedge clk); meas.conc <= 0;
		bus(0, OFF_FAULT, 0); check(d, 32'h0000_0001);
		check(loopMa10, 0);
		calPulse('{zeroOk: 1, default: 0});
		bus(0, OFF_FAULT, 0); check(d, 32'h0000_0000);
		calPulse('{spanFailRange: 1, default: 0});
		calPulse('{spanFailStab: 1, default: 0});
		calPulse('{spanFailClear: 1, default: 0});
		bus(0, OFF_FAULT, 0); check(d, 32'h0000_000E);
		calPulse('{spanOk: 1, lifeIn: 8'd24, default: 0});
		bus(0, OFF_FAULT, 0); check(d, 32'h0000_0000);
		check(sensorLife, 24);
		check(replaceCell, 1);
		calPulse('{spanOk: 1, lifeIn: 8'd25, default: 0});
		check(replaceCell, 0);
		bus(0, OFF_DAYS, 0); check(d, 32'h0000_0000);
	endtask : tCalFaults
	task automatic tMsgView();
		int k;
		@(posedge clk);
		meas.tempC <= 80;
		memFail <= 1;
		for (k = 0; k < 70000 && faultMsg !== 1'b1; k++) @(posedge clk);
		check(k >= MSG_MS && k <= MSG_MS + 10, 1);
		press(0, 1500);
		for (k = 0; k < 1500 && dispState != ST_VIEW; k++) @(posedge clk);
		check(k >= VIEW_MS && k <= VIEW_MS + 20, 1);
		for (k = 0; k < 50 && dispFault != 4'h7; k++) @(posedge clk);
		for (k = 0; k < 3000 && dispFault == 4'h7; k++) @(posedge clk);
		check(k >= STEP_MS && k <= STEP_MS + 10, 1);
		for (k = 0; k < 10 && dispFault != 4'hA; k++) @(posedge clk);
		check(dispFault, 4'hA);
		for (k = 0; k < 3000 && dispState == ST_VIEW; k++) @(posedge clk);
		check(k >= STEP_MS && k <= STEP_MS + 10, 1);
		@(posedge clk);
		meas.tempC <= 25;
		memFail <= 0;
	endtask : tMsgView
	task automatic tMenu();
		int k;
		bus(1, OFF_CTRL, 32'h0000_0004);
		repeat (3) @(posedge clk);
		check(dispState, ST_MENU);
		press(1, 4500);
		repeat (3950) @(posedge clk);
		check(dispState, ST_MENU);
		repeat (100) @(posedge clk);
		check(dispState, ST_SHOW);
		check(dispChoice, 0);
		repeat (500) @(posedge clk);
		press(1, 200);
		repeat (220) @(posedge clk);
		check(dispChoice, 1);
		press(0, 3400);
		repeat (2950) @(posedge clk);
		check(dispState, ST_SHOW);
		repeat (150) @(posedge clk);
		check(dispState, ST_MENU);
		for (k = 0; k < 20000 && dispState != ST_NORMAL; k++) @(posedge clk);
		check(k >= MENU_TO_MS && k <= MENU_TO_MS + 400, 1);
		bus(0, OFF_CTRL, 0);
		check(d, 32'h0000_0001);
	endtask : tMenu
	task automatic tLatch();
		bus(1, OFF_CTRL, 32'h0000_0001);
		@(posedge clk); loopBad <= 1;
		repeat (3) @(posedge clk);
		loopBad <= 0;
		repeat (3) @(posedge clk);
		check(faultLed, 1);
		press(1, 200);
		waitFor(faultLed, 0, 3000);
		check(faultLed, 0);
		bus(1, OFF_CTRL, 32'h0000_0000);
	endtask : tLatch
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		tResetRegs();
		tLimits();
		tOverAndCal();
		tCalFaults();
		tMsgView();
		tMenu();
		tLatch();
		final_report();
	end
endmodule : gfs_fault_supervisor_test
